// File: common/bram_pkg.sv
// Shared constants and types for the dual port block memory.
package bram_pkg;
  localparam int ADDR_W     = 14;
  localparam int DATA_W     = 36;
  localparam int BYTE_W     = 9;
  localparam int BYTE_CNT   = 2048;
  localparam int LANE_CNT   = 4;
  localparam int ARRAY_BITS = BYTE_CNT * BYTE_W;
  localparam int LAT_BYPASS = 1;
  localparam int LAT_OUTREG = 2;
  localparam logic [35:0] OUT_RST_VAL = 36'h0;
  localparam logic [8:0]  INIT_BYTE   = 9'h000;

  typedef enum logic [2:0] {
    W1  = 3'h0,
    W2  = 3'h1,
    W4  = 3'h2,
    W9  = 3'h3,
    W18 = 3'h4,
    W36 = 3'h5
  } width_e;

  typedef enum logic [1:0] {
    WM_NORMAL  = 2'h0,
    WM_THROUGH = 2'h1,
    WM_RBW     = 2'h2
  } write_mode_e;

  typedef enum logic [1:0] {
    PM_SINGLE      = 2'h0,
    PM_TRUE_DUAL   = 2'h1,
    PM_PSEUDO_DUAL = 2'h2
  } port_mode_e;
endpackage

// File: common/port_out_if.sv
// Link between the array core and one port's output stage.
`timescale 1ns/1ps
`default_nettype none
interface port_out_if;
  logic        load;
  logic [35:0] load_data;
  logic        out_reg_en;
  logic        sync_rst_sel;
  logic        port_rst;
  logic [35:0] dout;
  modport core  (output load, output load_data, output out_reg_en, output sync_rst_sel,
                 output port_rst, input dout);
  modport stage (input load, input load_data, input out_reg_en, input sync_rst_sel,
                 input port_rst, output dout);
endinterface
`default_nettype wire

// File: rtl/bram_out_stage.sv
// Output latch and optional output register of one memory port.
`timescale 1ns/1ps
`default_nettype none
module bram_out_stage
  import bram_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  port_out_if.stage   p
);
  logic        arst_n;
  logic [35:0] latch_r;
  logic [35:0] latch_nxt;
  logic [35:0] oreg_r;
  logic [35:0] oreg_nxt;

  // Global reset always, port reset only when asynchronous clearing is chosen.
  // asynchronous reset path
  assign arst_n = rst_n_i & ~(p.port_rst & ~p.sync_rst_sel);

  // Synchronous port reset wins over a pending load.
  always_comb
  begin
    latch_nxt = latch_r;
    oreg_nxt  = latch_r;
    if (p.sync_rst_sel && p.port_rst)
    begin
      latch_nxt = OUT_RST_VAL;
      oreg_nxt  = OUT_RST_VAL;
    end
    else if (p.load)
    begin
      latch_nxt = p.load_data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_r <= OUT_RST_VAL;
      oreg_r  <= OUT_RST_VAL;
    end
    else
    begin
      latch_r <= latch_nxt;
      oreg_r  <= oreg_nxt;
    end
  end

  assign p.dout = p.out_reg_en ? oreg_r : latch_r;

  AST_SYNC_RST_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    p.sync_rst_sel && p.port_rst |=> latch_r == OUT_RST_VAL && oreg_r == OUT_RST_VAL)
    else $error("Synchronous port reset did not clear the output latch.");
  AST_OREG_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !p.port_rst ##1 !p.port_rst |-> oreg_r == $past(latch_r))
    else $error("Output register did not follow the latch.");
endmodule // bram_out_stage
`default_nettype wire

// File: rtl/dual_port_block_ram.sv
// Two-port 18 Kbit block memory with width matching and write modes.
`timescale 1ns/1ps
`default_nettype none
module dual_port_block_ram
  import bram_pkg::*;
(
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RSTN_I,
  input  wire bram_pkg::port_mode_e PORT_MODE_I,
  input  wire bram_pkg::width_e     WIDTH_A_I,
  input  wire bram_pkg::width_e     WIDTH_B_I,
  input  wire bram_pkg::write_mode_e WMODE_A_I,
  input  wire bram_pkg::write_mode_e WMODE_B_I,
  input  wire logic                 OUT_REG_A_I,
  input  wire logic                 OUT_REG_B_I,
  input  wire logic                 SYNC_RST_A_I,
  input  wire logic                 SYNC_RST_B_I,
  input  wire logic                 PORT_A_OUTPUT_RESET_I,
  input  wire logic                 PORT_B_OUTPUT_RESET_I,
  input  wire logic                 CE_A_I,
  input  wire logic                 CE_B_I,
  input  wire logic                 WE_A_I,
  input  wire logic                 WE_B_I,
  input  wire logic [13:0]          ADDR_A_I,
  input  wire logic [13:0]          ADDR_B_I,
  input  wire logic [35:0]          DIN_A_I,
  input  wire logic [35:0]          DIN_B_I,
  input  wire logic [3:0]           BE_A_I,
  input  wire logic [3:0]           BE_B_I,
  output logic [35:0]               DOUT_A_O,
  output logic [35:0]               DOUT_B_O,
  output logic                      CFG_ERR_O
);
  // preload at configuration
  // The declaration holds the preload, so the clocked array process stays the only writer of mem_r.
  logic [8:0]  mem_r    [BYTE_CNT] = '{default: INIT_BYTE};
  logic [8:0]  mem_nxt  [BYTE_CNT];
  logic [1:0]  ce_in;
  logic [1:0]  we_in;
  logic [13:0] addr_in  [2];
  logic [35:0] din_in   [2];
  logic [3:0]  be_in    [2];
  width_e      wid      [2];
  write_mode_e wmode    [2];
  logic [1:0]  rd_ok;
  logic [1:0]  wr_ok;
  logic [1:0]  act_r;
  logic [1:0]  act_nxt;
  logic [1:0]  we_r;
  logic [1:0]  we_nxt;
  logic [13:0] addr_r   [2];
  logic [13:0] addr_nxt [2];
  logic [35:0] din_r    [2];
  logic [35:0] din_nxt  [2];
  logic [3:0]  be_r     [2];
  logic [3:0]  be_nxt   [2];
  logic [35:0] rd_word  [2];
  logic [1:0]  load;
  logic [35:0] load_data [2];
  logic        cfg_err_r;
  logic        cfg_err_nxt;
  logic [10:0] lane1_idx;

  port_out_if ifc [2] ();

  // Gather both ports into arrays so the logic below is written once.
  assign ce_in      = {CE_B_I, CE_A_I};
  assign we_in      = {WE_B_I, WE_A_I};
  assign addr_in[0] = ADDR_A_I;
  assign addr_in[1] = ADDR_B_I;
  assign din_in[0]  = DIN_A_I;
  assign din_in[1]  = DIN_B_I;
  assign be_in[0]   = BE_A_I;
  assign be_in[1]   = BE_B_I;
  assign wid[0]     = WIDTH_A_I;
  assign wid[1]     = WIDTH_B_I;
  assign wmode[0]   = WMODE_A_I;
  assign wmode[1]   = WMODE_B_I;

  // Bit shift of a narrow word inside the byte stream.
  function automatic logic [1:0] shift_of(input width_e w);
    case (w)
      W2:      shift_of = 2'h1;
      W4:      shift_of = 2'h2;
      default: shift_of = 2'h0;
    endcase
  endfunction

  // Nine-bit lanes per word; zero for the narrow shapes without parity.
  function automatic logic [2:0] lanes_of(input width_e w);
    case (w)
      W9:      lanes_of = 3'h1;
      W18:     lanes_of = 3'h2;
      W36:     lanes_of = 3'h4;
      default: lanes_of = 3'h0;
    endcase
  endfunction

  // word n starts right above word n-1
  function automatic logic [10:0] base_of(input logic [13:0] a, input width_e w);
    logic [13:0] pos;
    pos = a << shift_of(w);
    case (w)
      W9:      base_of = a[10:0];
      W18:     base_of = {a[9:0], 1'b0};
      W36:     base_of = {a[8:0], 2'h0};
      default: base_of = pos[13:3];
    endcase
  endfunction

  // Narrow shapes use the eight data bits of each byte, never the parity bit.
  function automatic logic [2:0] bit_of(input logic [13:0] a, input width_e w);
    logic [13:0] pos;
    pos = a << shift_of(w);
    bit_of = pos[2:0];
  endfunction

  // Width mask so unused upper data bits read as zero.
  function automatic logic [35:0] mask_of(input width_e w);
    case (w)
      W1:      mask_of = 36'h000000001;
      W2:      mask_of = 36'h000000003;
      W4:      mask_of = 36'h00000000f;
      W9:      mask_of = 36'h0000001ff;
      W18:     mask_of = 36'h00003ffff;
      default: mask_of = 36'hfffffffff;
    endcase
  endfunction

  // byte lanes keep their parity bit
  // each port reads with its own shape
  function automatic logic [35:0] read_word(input logic [13:0] a, input width_e w);
    logic [10:0] b;
    logic [2:0]  bt;
    logic [35:0] d;
    b  = base_of(a, w);
    bt = bit_of(a, w);
    d  = 36'h0;
    for (int l = 0; l < LANE_CNT; l++)
    begin
      if (l < int'(lanes_of(w)))
        d[BYTE_W*l +: BYTE_W] = mem_r[11'(b + 11'(l))];
    end
    if (lanes_of(w) == 3'h0)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (k < (1 << shift_of(w)))
          d[k] = mem_r[b][3'(bt + 3'(k))];
      end
    end
    read_word = d & mask_of(w);
  endfunction

  // Port permissions from the chosen mode; a x36 port in true dual-port is dead.
  // port roles per mode
  always_comb
  begin
    rd_ok       = 2'b11;
    wr_ok       = 2'b11;
    cfg_err_nxt = 1'b0;
    case (PORT_MODE_I)
      PM_SINGLE:      rd_ok[1] = 1'b0;
      PM_PSEUDO_DUAL: rd_ok[0] = 1'b0;
      default:        rd_ok    = 2'b11;
    endcase
    if (PORT_MODE_I == PM_SINGLE)
      wr_ok[1] = 1'b0;
    if (PORT_MODE_I == PM_PSEUDO_DUAL)
      wr_ok[1] = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      if (wid[p] > W36 || (PORT_MODE_I == PM_TRUE_DUAL && wid[p] == W36))
      begin
        rd_ok[p]    = 1'b0;
        wr_ok[p]    = 1'b0;
        cfg_err_nxt = 1'b1;
      end
    end
  end

  // Input capture; with the clock enable low the port holds and issues nothing.
  // per-port clock enable
  // address and data captured at the array input
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      addr_nxt[p] = addr_r[p];
      din_nxt[p]  = din_r[p];
      be_nxt[p]   = be_r[p];
      we_nxt[p]   = we_r[p];
      act_nxt[p]  = 1'b0;
      if (ce_in[p])
      begin
        addr_nxt[p] = addr_in[p];
        din_nxt[p]  = din_in[p];
        // byte enables only at x18 and x36
        be_nxt[p]   = (wid[p] == W18) ? {2'h0, be_in[p][1:0]} : (wid[p] == W36) ? be_in[p] : 4'hf;
        we_nxt[p]   = we_in[p] & wr_ok[p];
        act_nxt[p]  = we_in[p] ? wr_ok[p] : rd_ok[p];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      act_r     <= 2'h0;
      we_r      <= 2'h0;
      cfg_err_r <= 1'b0;
      for (int p = 0; p < 2; p++)
      begin
        addr_r[p] <= 14'h0;
        din_r[p]  <= 36'h0;
        be_r[p]   <= 4'h0;
      end
    end
    else
    begin
      act_r     <= act_nxt;
      we_r      <= we_nxt;
      cfg_err_r <= cfg_err_nxt;
      addr_r    <= addr_nxt;
      din_r     <= din_nxt;
      be_r      <= be_nxt;
    end
  end

  // Array update; port B is applied first so port A wins a same-byte collision.
  always_comb
  begin
    logic [10:0] b;
    logic [2:0]  bt;
    b  = 11'h0;
    bt = 3'h0;
    mem_nxt = mem_r;
    for (int q = 1; q >= 0; q--)
    begin
      b  = base_of(addr_r[q], wid[q]);
      bt = bit_of(addr_r[q], wid[q]);
      if (act_r[q] && we_r[q])
      begin
        for (int l = 0; l < LANE_CNT; l++)
        begin
          if (l < int'(lanes_of(wid[q])) && be_r[q][l])
            mem_nxt[11'(b + 11'(l))] = din_r[q][BYTE_W*l +: BYTE_W];
        end
        if (lanes_of(wid[q]) == 3'h0)
        begin
          for (int k = 0; k < 4; k++)
          begin
            if (k < (1 << shift_of(wid[q])))
              mem_nxt[b][3'(bt + 3'(k))] = din_r[q][k];
          end
        end
      end
    end
  end

  // The array has no reset, so a global reset never destroys preloaded contents.
  always_ff @(posedge REF_CLK_I)
  begin
    mem_r <= mem_nxt;
  end

  // Latch load decision per port and write mode.
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      rd_word[p]   = read_word(addr_r[p], wid[p]);
      load[p]      = 1'b0;
      load_data[p] = rd_word[p];
      if (act_r[p] && !we_r[p])
        load[p] = 1'b1;
      else if (act_r[p])
      begin
        case (wmode[p])
          WM_THROUGH: begin
            load[p]      = 1'b1;
            load_data[p] = din_r[p] & mask_of(wid[p]);
          end
          WM_RBW:     load[p] = (lanes_of(wid[p]) != 3'h0);
          default:    load[p] = 1'b0;
        endcase
      end
    end
  end

  // Output stages, one per port, each with its own local reset.
  // local reset reaches one port only
  for (genvar g = 0; g < 2; g++)
  begin : g_out
    assign ifc[g].load         = load[g];
    assign ifc[g].load_data    = load_data[g];
    assign ifc[g].out_reg_en   = (g == 0) ? OUT_REG_A_I : OUT_REG_B_I;
    assign ifc[g].sync_rst_sel = (g == 0) ? SYNC_RST_A_I : SYNC_RST_B_I;
    assign ifc[g].port_rst     = (g == 0) ? PORT_A_OUTPUT_RESET_I : PORT_B_OUTPUT_RESET_I;
    bram_out_stage u_stage (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RSTN_I),
      .p       (ifc[g])
    );
  end

  assign DOUT_A_O  = ifc[0].dout;
  assign DOUT_B_O  = ifc[1].dout;
  assign CFG_ERR_O = cfg_err_r;
  assign lane1_idx = 11'(base_of(addr_r[0], W18) + 11'h1);

  AST_NORMAL_HOLDS: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    CE_A_I && WE_A_I && WMODE_A_I == WM_NORMAL && !OUT_REG_A_I && !PORT_A_OUTPUT_RESET_I
    ##1 !PORT_A_OUTPUT_RESET_I |=> $stable(DOUT_A_O))
    else $error("Normal write changed the port A output.");
  AST_THROUGH_SHOWS: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    CE_A_I && WE_A_I && WMODE_A_I == WM_THROUGH && WIDTH_A_I == W9 && !OUT_REG_A_I
    && !PORT_A_OUTPUT_RESET_I ##1 !PORT_A_OUTPUT_RESET_I |=> DOUT_A_O == {27'h0, $past(DIN_A_I[8:0], 2)})
    else $error("Write-through data missing on port A.");
  AST_RBW_OLD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    act_r[0] && we_r[0] && WMODE_A_I == WM_RBW && WIDTH_A_I == W9 && !OUT_REG_A_I
    && !PORT_A_OUTPUT_RESET_I |=> DOUT_A_O == $past(rd_word[0]))
    else $error("Read-before-write did not show old data.");
  AST_READ_ONE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    act_r[0] && !we_r[0] && !OUT_REG_A_I && !PORT_A_OUTPUT_RESET_I |=> DOUT_A_O == $past(rd_word[0]))
    else $error("Bypassed read latency is not one cycle.");
  AST_READ_TWO: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    act_r[0] && !we_r[0] && OUT_REG_A_I && !PORT_A_OUTPUT_RESET_I ##1 OUT_REG_A_I
    && !PORT_A_OUTPUT_RESET_I |=> DOUT_A_O == $past(rd_word[0], 2))
    else $error("Registered read latency is not two cycles.");
  AST_A_ASYNC_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    PORT_A_OUTPUT_RESET_I && !SYNC_RST_A_I |-> DOUT_A_O == OUT_RST_VAL)
    else $error("Port A reset did not clear port A.");
  AST_B_UNTOUCHED: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    PORT_A_OUTPUT_RESET_I && !PORT_B_OUTPUT_RESET_I && !act_r[1] && !OUT_REG_B_I |=> $stable(DOUT_B_O))
    else $error("Port A reset disturbed port B.");
  AST_GLOBAL_CLEAR: assert property (@(posedge REF_CLK_I)
    !RSTN_I |-> DOUT_A_O == OUT_RST_VAL && DOUT_B_O == OUT_RST_VAL)
    else $error("Global reset left an output uncleared.");
  AST_BYTE_MASK: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    act_r[0] && we_r[0] && WIDTH_A_I == W18 && !be_r[0][1] && !(act_r[1] && we_r[1])
    |=> mem_r[$past(lane1_idx)] == $past(mem_r[lane1_idx]))
    else $error("Disabled byte lane was written.");
  AST_NO_TDP36: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    PORT_MODE_I == PM_TRUE_DUAL && WIDTH_A_I == W36 && CE_A_I |=> !act_r[0] && CFG_ERR_O)
    else $error("x36 port ran in true dual-port mode.");
  AST_PSEUDO_B_RO: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    PORT_MODE_I == PM_PSEUDO_DUAL && CE_B_I && WE_B_I |=> !(act_r[1] && we_r[1]))
    else $error("Port B wrote in pseudo dual-port mode.");

  COV_READ_A: cover property (@(posedge REF_CLK_I) act_r[0] && !we_r[0]);
  COV_DUAL_WRITE: cover property (@(posedge REF_CLK_I) act_r == 2'b11 && we_r == 2'b11);
  COV_MIXED_WIDTH: cover property (@(posedge REF_CLK_I) act_r == 2'b11 && WIDTH_A_I != WIDTH_B_I);
endmodule // dual_port_block_ram
`default_nettype wire

// File: verification/fabric_port.sv
// Fabric-side model that drives the request lines of one memory port.
`timescale 1ns/1ps
`default_nettype none
module fabric_port
(
  input  wire logic   clk_i,
  output logic        ce_o,
  output logic        we_o,
  output logic [13:0] addr_o,
  output logic [35:0] din_o,
  output logic [3:0]  be_o
);
  // Idle at time zero with the port disabled.
  initial
  begin
    ce_o = 1'b0;
    we_o = 1'b0;
    addr_o = 14'h0;
    din_o = 36'h0;
    be_o = 4'h0;
  end

  // Storage only: any pointer or flag logic stays out here in the fabric.
  task automatic req(input logic we, input logic [13:0] a, input logic [35:0] d, input logic [3:0] be);
    @(posedge clk_i);
    ce_o <= 1'b1;
    we_o <= we;
    addr_o <= a;
    din_o <= d;
    be_o <= be;
    @(posedge clk_i);
    // Released lines show the inverse so a stale value is never read as fresh.
    ce_o <= 1'b0;
    we_o <= ~we;
    addr_o <= ~a;
    din_o <= ~d;
    be_o <= ~be;
  endtask
endmodule // fabric_port
`default_nettype wire

// File: verification/dual_port_block_ram_tb_top.sv
// Self-checking bench for the dual port block memory.
`timescale 1ns/1ps
`default_nettype none
module dual_port_block_ram_tb_top;
  import bram_pkg::*;
  logic        ref_clk, rstn, ora, orb, sra, srb, pra, prb;
  port_mode_e  pmode;
  width_e      wa, wb;
  write_mode_e ma, mb;
  logic        ce_a, ce_b, we_a, we_b, cfg_err;
  logic [13:0] ad_a, ad_b;
  logic [35:0] di_a, di_b, do_a, do_b;
  logic [3:0]  be_a, be_b;
  int          n_errors = 0;
  int          compares = 0;

  dual_port_block_ram i_dut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .PORT_MODE_I(pmode),
    .WIDTH_A_I(wa), .WIDTH_B_I(wb), .WMODE_A_I(ma), .WMODE_B_I(mb), .OUT_REG_A_I(ora),
    .OUT_REG_B_I(orb), .SYNC_RST_A_I(sra), .SYNC_RST_B_I(srb), .PORT_A_OUTPUT_RESET_I(pra),
    .PORT_B_OUTPUT_RESET_I(prb), .CE_A_I(ce_a), .CE_B_I(ce_b), .WE_A_I(we_a), .WE_B_I(we_b),
    .ADDR_A_I(ad_a), .ADDR_B_I(ad_b), .DIN_A_I(di_a), .DIN_B_I(di_b), .BE_A_I(be_a),
    .BE_B_I(be_b), .DOUT_A_O(do_a), .DOUT_B_O(do_b), .CFG_ERR_O(cfg_err));
  fabric_port i_fab_a (.clk_i(ref_clk), .ce_o(ce_a), .we_o(we_a), .addr_o(ad_a), .din_o(di_a), .be_o(be_a));
  fabric_port i_fab_b (.clk_i(ref_clk), .ce_o(ce_b), .we_o(we_b), .addr_o(ad_b), .din_o(di_b), .be_o(be_b));

  // Clock at 40 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One request, then wait n edges past capture and sample once settled.
  task automatic acc(input bit p, input logic we, input logic [13:0] a, input logic [35:0] d,
                     input logic [3:0] be, input int n);
    if (p)
      i_fab_b.req(we, a, d, be);
    else
      i_fab_a.req(we, a, d, be);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Configuration changes only while both ports are idle; two edges let the error flag settle.
  task automatic cfg(input port_mode_e pm, input width_e x, input width_e y, input write_mode_e m);
    @(posedge ref_clk);
    pmode <= pm;
    wa <= x;
    wb <= y;
    ma <= m;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Watchdog: the sequence needs about 120 cycles.
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end

  initial
  begin
    rstn <= 1'b0; // Non-blocking, so the reset edge meets processes already waiting.
    pmode = PM_TRUE_DUAL;
    wa = W9;
    wb = W9;
    ma = WM_NORMAL;
    mb = WM_NORMAL;
    ora = 1'b0;
    orb = 1'b0;
    sra = 1'b0;
    srb = 1'b1;
    pra = 1'b0;
    prb = 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk("dout_a reset", do_a, 36'h0);
    chk("dout_b reset", do_b, 36'h0);
    acc(0, 0, 14'd9, 36'h0, 4'h0, 1);
    chk("preload read", do_a, {27'h0, INIT_BYTE});
    acc(0, 1, 14'd5, 36'h1a5, 4'h0, 1);
    chk("normal write out", do_a, {27'h0, INIT_BYTE});
    acc(1, 0, 14'd5, 36'h0, 4'h0, 1);
    chk("cross port read", do_b, 36'h1a5);
    cfg(PM_TRUE_DUAL, W18, W9, WM_NORMAL);
    acc(0, 1, 14'd3, {18'h0, 9'h15a, 9'h0c3}, 4'h3, 1);
    acc(1, 0, 14'd6, 36'h0, 4'h0, 1);
    chk("x18 low word", do_b, 36'h0c3);
    acc(1, 0, 14'd7, 36'h0, 4'h0, 1);
    chk("x18 high word", do_b, 36'h15a);
    cfg(PM_TRUE_DUAL, W18, W4, WM_NORMAL);
    acc(1, 0, 14'd12, 36'h0, 4'h0, 1);
    chk("x4 nibble 0", do_b, 36'h3);
    acc(1, 0, 14'd13, 36'h0, 4'h0, 1);
    chk("x4 nibble 1", do_b, 36'hc);
    cfg(PM_TRUE_DUAL, W18, W9, WM_NORMAL);
    acc(0, 1, 14'd3, {18'h0, 9'h0aa, 9'h055}, 4'h2, 1);
    acc(1, 0, 14'd6, 36'h0, 4'h0, 1);
    chk("masked lane", do_b, 36'h0c3);
    acc(1, 0, 14'd7, 36'h0, 4'h0, 1);
    chk("enabled lane", do_b, 36'h0aa);
    acc(0, 1, 14'd3, {18'h0, 9'h1ff, 9'h077}, 4'h1, 1);
    acc(1, 0, 14'd7, 36'h0, 4'h0, 1);
    chk("masked high lane", do_b, 36'h0aa);
    cfg(PM_TRUE_DUAL, W9, W9, WM_THROUGH);
    acc(0, 1, 14'd20, 36'hf_ffff_f1ee, 4'h0, 1);
    chk("write through", do_a, 36'h1ee);
    cfg(PM_TRUE_DUAL, W9, W9, WM_RBW);
    acc(0, 1, 14'd20, 36'h033, 4'h0, 1);
    chk("read before write", do_a, 36'h1ee);
    acc(0, 0, 14'd20, 36'h0, 4'h0, 1);
    chk("rbw stored", do_a, 36'h033);
    cfg(PM_TRUE_DUAL, W9, W9, WM_NORMAL);
    @(posedge ref_clk);
    ora <= 1'b1;
    acc(0, 0, 14'd5, 36'h0, 4'h0, 1);
    chk("outreg early", do_a, 36'h033);
    @(posedge ref_clk);
    #1;
    chk("outreg late", do_a, 36'h1a5);
    @(posedge ref_clk);
    pra <= 1'b1;
    #1;
    chk("async port reset a", do_a, 36'h0);
    chk("port b untouched", do_b, 36'h0aa);
    @(posedge ref_clk);
    pra <= 1'b0;
    prb <= 1'b1;
    #1;
    chk("sync reset waits", do_b, 36'h0aa);
    @(posedge ref_clk);
    prb <= 1'b0;
    ora <= 1'b0;
    #1;
    chk("sync port reset b", do_b, 36'h0);
    cfg(PM_PSEUDO_DUAL, W36, W36, WM_NORMAL);
    chk("pseudo x36 allowed", {35'h0, cfg_err}, 36'h0);
    acc(0, 1, 14'd2, 36'h9_8765_4321, 4'hf, 1);
    acc(1, 1, 14'd2, 36'h0, 4'hf, 1);
    acc(1, 0, 14'd2, 36'h0, 4'h0, 1);
    chk("pseudo x36 read", do_b, 36'h9_8765_4321);
    cfg(PM_TRUE_DUAL, W36, W9, WM_NORMAL);
    chk("true dual x36", {35'h0, cfg_err}, 36'h1);
    acc(0, 1, 14'd2, 36'h0, 4'hf, 1);
    cfg(PM_SINGLE, W9, W9, WM_NORMAL);
    chk("single no error", {35'h0, cfg_err}, 36'h0);
    acc(1, 1, 14'd5, 36'h0, 4'h0, 1);
    acc(0, 0, 14'd5, 36'h0, 4'h0, 1);
    chk("single b ignored", do_a, 36'h1a5);
    acc(0, 0, 14'd8, 36'h0, 4'h0, 1);
    chk("tdp x36 write refused", do_a, 36'h121);
    @(posedge ref_clk);
    rstn <= 1'b0;
    #1;
    chk("global reset a", do_a, 36'h0);
    chk("global reset b", do_b, 36'h0);
    test_done();
  end
endmodule // dual_port_block_ram_tb_top
`default_nettype wire
